// >>> line_ctl_regs.vh
// register offsets, field positions, reset values and timing counts for the line control block
`ifndef LINE_CTL_REGS_VH
`define LINE_CTL_REGS_VH

// register map (byte addresses, one word each)
`define LICTL_OFS 8'h10
`define STATUS_OFS 8'h14
`define SAMPLE_DIV_OFS 8'h18

// field positions of the control register
`define TERM_OFF_OR_SQUELCH_BIT 7
`define HOOK_RELEASE_SPEED_BIT 6
`define AC_TERM_SELECT_BIT 5
`define RECURSIVE_FILTER_SELECT_BIT 4
`define DC_TERM_MODE_HI 3
`define DC_TERM_MODE_LO 2
`define RINGER_IMPEDANCE_SYNTH_BIT 1
`define RING_THRESHOLD_SELECT_BIT 0

// bit positions of the read-only status word
`define STATUS_TERM_OFF_BIT 0
`define STATUS_SQUELCH_BIT 1
`define STATUS_BUSY_BIT 2

// reset values
`define LICTL_RESET 8'h08
`define SAMPLE_DIV_RESET 16'h04e1

// off-hook counter lengths in sample periods
`define HOOK_COUNT_FAST 13'h0400
`define HOOK_COUNT_SLOW 13'h1000

// dc termination mode codes
`define DCT_LOW_VOLTAGE 2'h0
`define DCT_JAPAN 2'h1
`define DCT_STANDARD 2'h2
`define DCT_CURRENT_LIMIT 2'h3

// transmit level codes in dBm, two's complement
`define TX_LEVEL_M5 4'hb
`define TX_LEVEL_M3 4'hd
`define TX_LEVEL_M1 4'hf

`endif

// >>> line_ctl.v
// line interface control register with avalon slave and off-hook release counter
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "line_ctl_regs.vh"

module line_ctl
(
	input wire CORE_CLK, // 10 MHz core clock
	input wire ARST_N, // asynchronous reset, active low
	input wire [7:0] AVS_ADDRESS, // byte address
	input wire AVS_READ, // read request
	input wire AVS_WRITE, // write request
	input wire [31:0] AVS_WRITEDATA, // write data
	input wire [3:0] AVS_BYTEENABLE, // byte lanes
	output wire AVS_WAITREQUEST, // stall until answer cycle
	output reg [31:0] AVS_READDATA, // read data
	output reg [1:0] AVS_RESPONSE, // 00 okay, 10 slave error
	input wire OFF_HOOK, // line is off-hook
	input wire NEW_LINE_SIDE, // line side supports squelch
	output reg DC_TERM_OFF, // dc termination disabled, high dc impedance
	output reg RING_SQUELCH, // enhanced ring network squelch
	output reg HOOK_RELEASE_BUSY, // off-hook counter still running
	output reg AC_TERM_COMPLEX, // complex ac termination
	output reg IIR_FILTER, // iir filtering on tx and rx
	output reg [1:0] DC_TERM_MODE, // dc termination mode
	output reg [3:0] TX_LEVEL_DBM, // transmit level, signed dBm
	output reg RINGER_SYNTH, // synthesized ringer impedance
	output reg RING_THRESH_HIGH, // 17 to 33 Vrms band
	output reg SAMPLE_TICK // one pulse per sample period
);

	// ==========================================================
	// functions

	// transmit level for each dc termination mode
	function [3:0] tx_level;
		input [1:0] mode;
		begin
			case (mode)
			`DCT_LOW_VOLTAGE: tx_level = `TX_LEVEL_M5;
			`DCT_JAPAN: tx_level = `TX_LEVEL_M3;
			`DCT_STANDARD: tx_level = `TX_LEVEL_M1;
			`DCT_CURRENT_LIMIT: tx_level = `TX_LEVEL_M1;
			default: tx_level = `TX_LEVEL_M1;
			endcase
		end
	endfunction

	// byte-lane merge of write data
	function [7:0] lane0_merge;
		input [7:0] old;
		input [31:0] wdata;
		input [3:0] be;
		begin
			lane0_merge = be[0] ? wdata[7:0] : old;
		end
	endfunction

	// dc termination field of a control word
	function [1:0] dc_mode_of;
		input [7:0] ctl;
		begin
			dc_mode_of = ctl[`DC_TERM_MODE_HI:`DC_TERM_MODE_LO];
		end
	endfunction

	// status word with the termination, squelch and release flags in place
	function [31:0] status_word;
		input term_off;
		input squelch;
		input busy;
		begin
			status_word = 32'h0000_0000;
			status_word[`STATUS_TERM_OFF_BIT] = term_off;
			status_word[`STATUS_SQUELCH_BIT] = squelch;
			status_word[`STATUS_BUSY_BIT] = busy;
		end
	endfunction

	// off-hook counter length for the on-hook speed bit
	function [12:0] hook_length;
		input slow;
		begin
			hook_length = slow ? `HOOK_COUNT_SLOW : `HOOK_COUNT_FAST;
		end
	endfunction

	// ==========================================================
	// bus slave state machine

	// every transfer waits exactly one cycle: the request is seen in idle,
	// read data is captured on that edge and the answer cycle follows
	localparam [1:0] S_IDLE = 2'b01;
	localparam [1:0] S_ANSWER = 2'b10;

	reg [1:0] state;
	reg [1:0] next_state;
	reg [7:0] lictl;
	reg [15:0] sample_div;
	reg [15:0] div_count;
	reg [12:0] hook_count;
	reg last_off_hook;
	reg [31:0] next_rdata;
	reg [1:0] next_resp;
	wire request;
	wire answer;
	wire hit_ctl;
	wire hit_status;
	wire hit_div;

	assign request = AVS_READ | AVS_WRITE;
	assign answer = state[1];
	assign AVS_WAITREQUEST = request & ~answer;
	assign hit_ctl = (AVS_ADDRESS == `LICTL_OFS);
	assign hit_status = (AVS_ADDRESS == `STATUS_OFS);
	assign hit_div = (AVS_ADDRESS == `SAMPLE_DIV_OFS);

	// next state: one wait cycle, then answer
	always @*
	begin
		case (state)
		S_IDLE: next_state = request ? S_ANSWER : S_IDLE;
		S_ANSWER: next_state = S_IDLE;
		default: next_state = S_IDLE;
		endcase
	end

	// state register
	always @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			state <= S_IDLE;
		else
			state <= next_state;
	end

	// read data and response decode
	// unmapped addresses read as zero with a slave error; the status word is
	// read-only and writes to it are dropped without an error
	always @*
	begin
		next_rdata = 32'h0000_0000;
		next_resp = 2'h0;
		if (hit_ctl)
			next_rdata = {24'h00_0000, lictl};
		else if (hit_status)
			next_rdata = status_word(DC_TERM_OFF, RING_SQUELCH, HOOK_RELEASE_BUSY);
		else if (hit_div)
			next_rdata = {16'h0000, sample_div};
		else
			next_resp = 2'h2;
	end

	// read data and response captured while the request waits
	always @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			AVS_READDATA <= 32'h0000_0000;
			AVS_RESPONSE <= 2'h0;
		end
		else if (request && !answer)
		begin
			AVS_READDATA <= AVS_READ ? next_rdata : 32'h0000_0000;
			AVS_RESPONSE <= next_resp;
		end
	end

	// ==========================================================
	// writable registers

	// writes land on the answer edge
	// the control register takes byte lane 0 only, the divider lanes 0 and 1
	always @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			lictl <= `LICTL_RESET;
			sample_div <= `SAMPLE_DIV_RESET;
		end
		else if (AVS_WRITE && answer)
		begin
			if (hit_ctl)
				lictl <= lane0_merge(lictl, AVS_WRITEDATA, AVS_BYTEENABLE);
			if (hit_div)
			begin
				if (AVS_BYTEENABLE[0])
					sample_div[7:0] <= AVS_WRITEDATA[7:0];
				if (AVS_BYTEENABLE[1])
					sample_div[15:8] <= AVS_WRITEDATA[15:8];
			end
		end
	end

	// ==========================================================
	// sample rate divider

	// one tick each sample_div + 1 core cycles
	// a divider of zero ticks on every core cycle, and a new value below the
	// running count ends the current period at once
	always @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			div_count <= 16'h0000;
			SAMPLE_TICK <= 1'b0;
		end
		else if (div_count >= sample_div)
		begin
			div_count <= 16'h0000;
			SAMPLE_TICK <= 1'b1;
		end
		else
		begin
			div_count <= div_count + 16'h0001;
			SAMPLE_TICK <= 1'b0;
		end
	end

	// ==========================================================
	// off-hook release counter

	// starts on the off-hook to on-hook edge; length fixed at that edge
	// going off-hook again cancels a running release; the speed bit is read
	// only on the falling edge, so later writes leave the running count alone
	always @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			last_off_hook <= 1'b0;
			hook_count <= 13'h0000;
			HOOK_RELEASE_BUSY <= 1'b0;
		end
		else
		begin
			last_off_hook <= OFF_HOOK;
			if (OFF_HOOK)
			begin
				hook_count <= 13'h0000;
				HOOK_RELEASE_BUSY <= 1'b0;
			end
			else if (last_off_hook)
			begin
				hook_count <= hook_length(lictl[`HOOK_RELEASE_SPEED_BIT]);
				HOOK_RELEASE_BUSY <= 1'b1;
			end
			// step per sample
			// busy drops on the tick that takes the count to zero
			else if (SAMPLE_TICK && hook_count != 13'h0000)
			begin
				hook_count <= hook_count - 13'h0001;
				HOOK_RELEASE_BUSY <= (hook_count != 13'h0001);
			end
		end
	end

	// ==========================================================
	// field decode to analog controls

	// registered controls follow the register one cycle later
	// bit 7 is only routed here; setting it for caller id and clearing it
	// before the next ring is left to software
	always @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			DC_TERM_OFF <= 1'b0;
			RING_SQUELCH <= 1'b0;
			AC_TERM_COMPLEX <= 1'b0;
			IIR_FILTER <= 1'b0;
			DC_TERM_MODE <= `DCT_STANDARD;
			TX_LEVEL_DBM <= `TX_LEVEL_M1;
			RINGER_SYNTH <= 1'b0;
			RING_THRESH_HIGH <= 1'b0;
		end
		else
		begin
			DC_TERM_OFF <= lictl[`TERM_OFF_OR_SQUELCH_BIT] & OFF_HOOK;
			RING_SQUELCH <= lictl[`TERM_OFF_OR_SQUELCH_BIT] & ~OFF_HOOK & NEW_LINE_SIDE;
			AC_TERM_COMPLEX <= lictl[`AC_TERM_SELECT_BIT];
			IIR_FILTER <= lictl[`RECURSIVE_FILTER_SELECT_BIT];
			DC_TERM_MODE <= dc_mode_of(lictl);
			TX_LEVEL_DBM <= tx_level(dc_mode_of(lictl));
			RINGER_SYNTH <= lictl[`RINGER_IMPEDANCE_SYNTH_BIT];
			RING_THRESH_HIGH <= lictl[`RING_THRESHOLD_SELECT_BIT];
		end
	end

endmodule // line_ctl

// >>> line_ctl_props.sv
// checker for the line control block
`timescale 1ns/1ps
module line_ctl_props
(
	input wire CORE_CLK,
	input wire ARST_N,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire AVS_WAITREQUEST,
	input wire OFF_HOOK,
	input wire DC_TERM_OFF,
	input wire RING_SQUELCH,
	input wire HOOK_RELEASE_BUSY,
	input wire [1:0] DC_TERM_MODE,
	input wire [3:0] TX_LEVEL_DBM,
	input wire SAMPLE_TICK
);
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (!ARST_N);
	reg [12:0] ticks;
	// count sample ticks while the release counter runs
	always @(posedge CORE_CLK or negedge ARST_N)
		if (!ARST_N)
			ticks <= 13'h0;
		else if (!HOOK_RELEASE_BUSY)
			ticks <= 13'h0;
		else
			ticks <= ticks + {12'h0, SAMPLE_TICK};
	// ====
	// bus handshake
	sequence held_s;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
	endsequence
	one_wait_a: assert property (held_s |=> !AVS_WAITREQUEST)
		else $error("no answer");
	idle_ready_a: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
		else $error("stall when idle");
	// ====
	// control outputs
	tx_level_a: assert property (
		TX_LEVEL_DBM == (DC_TERM_MODE == 2'h0 ? 4'hb : DC_TERM_MODE == 2'h1 ? 4'hd : 4'hf))
		else $error("tx level");
	term_onhook_a: assert property (
		!OFF_HOOK [*3] |-> !DC_TERM_OFF)
		else $error("term off on-hook");
	squelch_offhook_a: assert property (
		OFF_HOOK [*3] |-> !RING_SQUELCH)
		else $error("squelch off-hook");
	busy_start_a: assert property (
		$fell(OFF_HOOK) |-> ##[1:2] HOOK_RELEASE_BUSY)
		else $error("release not started");
	hook_clear_a: assert property (
		OFF_HOOK [*3] |-> !HOOK_RELEASE_BUSY)
		else $error("busy off-hook");
	busy_len_a: assert property (
		$fell(HOOK_RELEASE_BUSY) && !OFF_HOOK |-> ticks inside {[13'h3ff:13'h401], [13'hfff:13'h1001]})
		else $error("release length");
	tick_pulse_a: assert property (SAMPLE_TICK |=> !SAMPLE_TICK)
		else $error("tick too long");
endmodule // line_ctl_props

bind line_ctl line_ctl_props props (.*);

// >>> host_bfm.sv
// host software model on the avalon register bus
`timescale 1ns/1ps
module host_bfm
(
	input wire CORE_CLK,
	input wire AVS_WAITREQUEST,
	input wire [31:0] AVS_READDATA,
	input wire [1:0] AVS_RESPONSE,
	output reg [7:0] AVS_ADDRESS = 8'h0,
	output reg AVS_READ = 1'b0,
	output reg AVS_WRITE = 1'b0,
	output reg [31:0] AVS_WRITEDATA = 32'h0,
	output reg [3:0] AVS_BYTEENABLE = 4'hf
);
	// byte lanes driven with every transfer, all four unless set otherwise
	reg [3:0] lanes = 4'hf;

	// pick the byte lanes of the transfers that follow
	task set_lanes(input [3:0] be);
		begin
			lanes = be;
		end
	endtask

	// one transfer, held until waitrequest is seen low or 20 cycles have passed
	task xfer(input rd, input [7:0] a, input [31:0] d, output [31:0] q, output [1:0] r,
		output ok);
		integer n;
		begin
			@(posedge CORE_CLK);
			AVS_ADDRESS <= a;
			AVS_READ <= rd;
			AVS_WRITE <= !rd;
			AVS_WRITEDATA <= d;
			AVS_BYTEENABLE <= lanes;
			ok = 1'b0;
			for (n = 0; n < 20 && !ok; n = n + 1)
			begin
				@(posedge CORE_CLK);
				ok = AVS_WAITREQUEST === 1'b0;
			end
			q = AVS_READDATA;
			r = AVS_RESPONSE;
			AVS_READ <= 1'b0;
			AVS_WRITE <= 1'b0;
		end
	endtask
endmodule // host_bfm

// >>> tb_top.sv
// self-checking bench for the line control block
`timescale 1ns/1ps
module tb_top;
	reg CORE_CLK = 1'b0;
	reg ARST_N = 1'b0;
	reg OFF_HOOK = 1'b0;
	reg NEW_LINE_SIDE = 1'b0;
	wire [7:0] AVS_ADDRESS;
	wire [31:0] AVS_WRITEDATA, AVS_READDATA;
	wire [3:0] AVS_BYTEENABLE, TX_LEVEL_DBM;
	wire [1:0] AVS_RESPONSE, DC_TERM_MODE;
	wire AVS_READ, AVS_WRITE, AVS_WAITREQUEST, DC_TERM_OFF, RING_SQUELCH;
	wire HOOK_RELEASE_BUSY, AC_TERM_COMPLEX, IIR_FILTER, RINGER_SYNTH, RING_THRESH_HIGH;
	wire SAMPLE_TICK;
	integer error_cnt = 0;
	integer cmp_count = 0;
	line_ctl dut (.*);
	host_bfm bfm (.*);
	always #50 CORE_CLK = ~CORE_CLK;
	// ====
	// shared tasks
	task stop_test;
		begin
			$display("errors %0d compares %0d", error_cnt, cmp_count);
			if (error_cnt == 0 && cmp_count > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e)
			begin
				error_cnt = error_cnt + 1;
				$display("[ERR] %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task bus(input rd, input [7:0] a, input [31:0] d, input [31:0] eq, input [1:0] er);
		reg [31:0] q;
		reg [1:0] r;
		reg ok;
		begin
			bfm.xfer(rd, a, d, q, r, ok);
			chk({31'h0, ok}, 32'h1);
			if (ok !== 1'b1)
				stop_test;
			if (rd)
				chk({q[31:0]}, eq);
			if (rd)
				chk({30'h0, r}, {30'h0, er});
		end
	endtask
	task hook(input h, input s);
		begin
			@(posedge CORE_CLK);
			OFF_HOOK <= h;
			NEW_LINE_SIDE <= s;
			repeat (3) @(posedge CORE_CLK);
			@(negedge CORE_CLK);
		end
	endtask
	// ====
	// scenarios
	task t_reset;
		begin
			ARST_N <= 1'b0;
			repeat (3) @(posedge CORE_CLK);
			ARST_N <= 1'b1;
			@(negedge CORE_CLK);
			chk({DC_TERM_MODE, TX_LEVEL_DBM, AC_TERM_COMPLEX, RING_SQUELCH}, 32'hbc);
			bus(1'b1, 8'h10, 32'h0, 32'h08, 2'h0);
			bus(1'b1, 8'h18, 32'h0, 32'h4e1, 2'h0);
		end
	endtask
	task t_fields;
		integer i;
		reg [7:0] v;
		begin
			for (i = 0; i < 4; i = i + 1)
			begin
				v = {2'h0, i[1:0], i[1:0], i[1:0]};
				bus(1'b0, 8'h10, {24'h0, v}, 32'h0, 2'h0);
				bus(1'b1, 8'h10, 32'h0, {24'h0, v}, 2'h0);
				@(negedge CORE_CLK);
				chk({AC_TERM_COMPLEX, IIR_FILTER, DC_TERM_MODE, RINGER_SYNTH, RING_THRESH_HIGH},
					{26'h0, v[5:0]});
				chk(TX_LEVEL_DBM, i == 0 ? 4'hb : i == 1 ? 4'hd : 4'hf);
			end
			bus(1'b1, 8'h1c, 32'h0, 32'h0, 2'h2);
			bus(1'b0, 8'h1c, 32'hff, 32'h0, 2'h0);
			bfm.set_lanes(4'he);
			bus(1'b0, 8'h10, 32'hff, 32'h0, 2'h0);
			bfm.set_lanes(4'hf);
			bus(1'b1, 8'h10, 32'h0, 32'h3f, 2'h0);
			bus(1'b1, 8'h18, 32'h0, 32'h4e1, 2'h0);
		end
	endtask
	task t_bit7;
		begin
			bus(1'b0, 8'h18, 32'h1, 32'h0, 2'h0);
			bus(1'b1, 8'h18, 32'h0, 32'h1, 2'h0);
			bus(1'b0, 8'h10, 32'h88, 32'h0, 2'h0);
			hook(1'b1, 1'b0);
			chk({DC_TERM_OFF, RING_SQUELCH}, 32'h2);
			hook(1'b1, 1'b1);
			chk({DC_TERM_OFF, RING_SQUELCH}, 32'h2);
			hook(1'b0, 1'b1);
			chk({DC_TERM_OFF, RING_SQUELCH}, 32'h1);
			bus(1'b1, 8'h14, 32'h0, 32'h6, 2'h0);
			hook(1'b0, 1'b0);
			chk(RING_SQUELCH, 32'h0);
			bus(1'b0, 8'h10, 32'h08, 32'h0, 2'h0);
			hook(1'b0, 1'b1);
			chk(RING_SQUELCH, 32'h0);
		end
	endtask
	task t_hook(input [7:0] v, input [12:0] n);
		integer c, k;
		begin
			bus(1'b0, 8'h10, {24'h0, v}, 32'h0, 2'h0);
			hook(1'b1, 1'b1);
			chk(HOOK_RELEASE_BUSY, 32'h0);
			hook(1'b0, 1'b1);
			c = 0;
			for (k = 0; k < 20000 && HOOK_RELEASE_BUSY === 1'b1; k = k + 1)
			begin
				@(negedge CORE_CLK);
				c = c + SAMPLE_TICK;
			end
			chk(k < 20000 && c > n - 4 && c < n + 2, 32'h1);
			if (k == 20000)
				stop_test;
		end
	endtask
	initial
	begin
		t_reset;
		t_fields;
		t_bit7;
		t_hook(8'h08, 13'h400);
		t_hook(8'h48, 13'h1000);
		@(posedge CORE_CLK);
		t_reset;
		stop_test;
	end
endmodule // tb_top
